/* File: half_bridge_spi_frame_logic.sv */
// Operation
// - A frame is one address byte, then one data byte, in that order.
// - Bit 7 selects read only, or write / read-and-clear.
// - Target register index comes from address bits six to two.
// - During the address byte, shift out error flag then global status.
// - During the data byte, shift out the addressed register.
// - Chained targets share select and clock; output feeds next input.
// - Before first rising clock, output own flag OR serial input.
// - Status bytes reach the controller in reverse target order.
// - Response bytes then reach the controller in target order.
// - Select low without clocks shows the combined flag.
// - Faults after the address byte report in the next frame's status.
// - New fault in the targeted status register cancels its clear.
// - Load fault during its address byte shows in the data byte, not in status.
// - Sample input on falling clock, update output on rising clock.
// - Clock count not zero and not a multiple of eight from sixteen to 248 is an error.
// - Command to an unassigned address is a protocol error.
// - Error flag set on any fault except a blanked open load, or after power-on reset.
`timescale 1ns/1ps
module half_bridge_spi_frame_logic
  import hb_spi_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_sclk,
  input wire logic i_chip_select_low_n,
  input wire logic i_serial_in,
  input wire logic [7:0] i_open_load,
  input wire logic [7:0] i_overcurrent,
  input wire logic i_vs_uv,
  input wire logic i_vs_ov,
  input wire logic i_tsd,
  input wire logic i_tpw,
  output logic o_serial_out,
  output logic o_serial_out_oe,
  output logic [7:0] o_switch_enables,
  output logic [1:0] o_clock_mod_sel
);

  sys_state_t s_r;
  sys_state_t s_nxt;
  rx_state_t rx_r;
  rx_state_t rx_nxt;
  tx_state_t tx_r;
  tx_state_t tx_nxt;
  logic started_r;

  // Global status byte from its parts
  function automatic logic [7:0] status_byte(input global_bits_t gb, input logic [7:0] ol, input logic [7:0] oc);
    logic [7:0] b;
    b = 8'h00;
    b[GS_SPI_ERR] = gb.spi_err;
    b[GS_LOAD] = |{ol, oc};
    b[GS_UV] = gb.uv;
    b[GS_OV] = gb.ov;
    b[GS_NPOR] = gb.npor;
    b[GS_TSD] = gb.tsd;
    b[GS_TPW] = gb.tpw;
    return b;
  endfunction

  function automatic logic is_mapped(input logic [4:0] idx);
    return (idx == ADDR_SWITCH) || (idx == ADDR_OPEN_LOAD) || (idx == ADDR_GLOBAL) ||
           (idx == ADDR_CLK_MOD) || (idx == ADDR_OVERCURRENT) || (idx == ADDR_VARIANT) ||
           (idx == ADDR_BLANKING);
  endfunction

  // System domain: register file, fault capture, frame execution
  logic frame_end;
  logic in_frame;
  logic cnt_ok;
  logic bad;
  logic exec;
  logic [4:0] idx;
  logic [7:0] ol_clr;
  logic [7:0] oc_clr;
  logic g_clr;
  logic g_evt;
  logic ol_hidden;
  logic clocked;
  logic [7:0] guarded;

  always_comb
  begin
    s_nxt = s_r;
    ol_clr = 8'h00;
    oc_clr = 8'h00;
    g_clr = 1'b0;
    s_nxt.cs_s1 = i_chip_select_low_n;
    s_nxt.cs_s2 = s_r.cs_s1;
    s_nxt.cs_d = s_r.cs_s2;
    // One-bit frame toggle from the link side, so two flops are a safe crossing
    s_nxt.tgl_s1 = rx_r.frame_tgl;
    s_nxt.tgl_s2 = s_r.tgl_s1;
    frame_end = s_r.cs_s2 & ~s_r.cs_d;
    in_frame = ~s_r.cs_s2;
    idx = rx_r.addr[IDX_MSB:IDX_LSB];
    // A zero-clock frame leaves the last command behind; never run it twice
    clocked = s_r.tgl_s2 != s_r.tgl_seen;
    // Link words are stable here: the clock is idle once select is high
    cnt_ok = (rx_r.cnt >= MIN_FRAME_BITS) && (rx_r.cnt[2:0] == 3'h0);
    bad = clocked &&
          (!cnt_ok || !rx_r.addr[FRAME_BIT] || !rx_r.found || !is_mapped(idx));
    exec = frame_end && clocked && !bad && rx_r.addr[OPERATION_BIT];
    g_evt = i_vs_uv | i_vs_ov | i_tsd | i_tpw;
    if (exec)
    begin
      unique case (idx)
        ADDR_SWITCH: s_nxt.ctrl.switch_en = rx_r.data;
        ADDR_CLK_MOD: s_nxt.ctrl.clk_mod = rx_r.data & CLK_MOD_MASK;
        ADDR_BLANKING: s_nxt.ctrl.blanking = rx_r.data & BLANK_MASK;
        // A fresh fault during the frame cancels the clear
        ADDR_OPEN_LOAD: ol_clr = s_r.new_ol ? 8'h00 : 8'hff;
        ADDR_OVERCURRENT: oc_clr = s_r.new_oc ? 8'h00 : 8'hff;
        ADDR_GLOBAL: g_clr = ~s_r.new_g;
        default: ;
      endcase
    end
    // Set wins over clear on every sticky bit
    s_nxt.ol = (s_r.ol & ~ol_clr) | i_open_load;
    s_nxt.oc = (s_r.oc & ~oc_clr) | i_overcurrent;
    s_nxt.gb.spi_err = (s_r.gb.spi_err & ~g_clr) | (frame_end & bad);
    s_nxt.gb.uv = (s_r.gb.uv & ~g_clr) | i_vs_uv;
    s_nxt.gb.ov = (s_r.gb.ov & ~g_clr) | i_vs_ov;
    s_nxt.gb.tsd = (s_r.gb.tsd & ~g_clr) | i_tsd;
    s_nxt.gb.tpw = (s_r.gb.tpw & ~g_clr) | i_tpw;
    s_nxt.gb.npor = s_r.gb.npor | g_clr;
    // Faults arriving during a frame are remembered for the clear decision
    if (frame_end)
    begin
      s_nxt.tgl_seen = s_r.tgl_s2;
      s_nxt.new_ol = 1'b0;
      s_nxt.new_oc = 1'b0;
      s_nxt.new_g = 1'b0;
    end
    else if (in_frame)
    begin
      s_nxt.new_ol = s_r.new_ol | (|i_open_load);
      s_nxt.new_oc = s_r.new_oc | (|i_overcurrent);
      s_nxt.new_g = s_r.new_g | g_evt;
    end
    // Frozen status copy for the link; in-frame faults wait for the next one
    if (!in_frame)
    begin
      s_nxt.shadow = status_byte(s_r.gb, s_r.ol, s_r.oc);
    end
    ol_hidden = s_r.ctrl.blanking[BLANK_BIT];
    s_nxt.combined_fault_flag = s_r.gb.spi_err | s_r.gb.uv | s_r.gb.ov | ~s_r.gb.npor | s_r.gb.tsd | s_r.gb.tpw |
                (|s_r.oc) | ((|s_r.ol) & ~ol_hidden);
    s_nxt.clk_mod_out = s_r.ctrl.clk_mod[7:6];
    s_nxt.switch_out = guarded;
  end

  // Both switches of one half-bridge on would short the supply
  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : g_guard
      assign guarded[2*g+1:2*g] = (&s_r.ctrl.switch_en[2*g+1:2*g]) ? 2'b00 :
                                  s_r.ctrl.switch_en[2*g+1:2*g];
    end
  endgenerate

  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      s_r <= '0;
      s_r.cs_s1 <= 1'b1;
      s_r.cs_s2 <= 1'b1;
      s_r.cs_d <= 1'b1;
      s_r.ctrl.switch_en <= SWITCH_RST;
      s_r.ctrl.clk_mod <= CLK_MOD_RST;
      s_r.ctrl.blanking <= BLANK_RST;
      s_r.ol <= STATUS_RST;
      s_r.oc <= STATUS_RST;
      s_r.combined_fault_flag <= 1'b1;
      s_r.clk_mod_out <= 2'b11;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  // Register read view for the response byte
  function automatic logic [7:0] read_reg(input logic [4:0] ri, input ctrl_regs_t c, input logic [7:0] gs,
                                          input logic [7:0] ol, input logic [7:0] oc);
    logic [7:0] v;
    v = 8'h00;
    unique case (ri)
      ADDR_SWITCH: v = c.switch_en;
      ADDR_CLK_MOD: v = c.clk_mod;
      ADDR_BLANKING: v = c.blanking;
      ADDR_VARIANT: v = VARIANT_ID;
      ADDR_GLOBAL: v = gs;
      ADDR_OPEN_LOAD: v = ol;
      ADDR_OVERCURRENT: v = oc;
      default: v = 8'h00;
    endcase
    return v;
  endfunction

  // Frame start marker, cleared while select is high
  always_ff @(negedge i_sclk or negedge i_rst_n or posedge i_chip_select_low_n)
  begin
    if (!i_rst_n)
    begin
      started_r <= 1'b0;
    end
    else if (i_chip_select_low_n)
    begin
      started_r <= 1'b0;
    end
    else
    begin
      started_r <= 1'b1;
    end
  end

  // Link domain, falling edge: capture, byte framing, next output byte
  logic [7:0] rx_byte;

  always_comb
  begin
    rx_nxt = rx_r;
    rx_nxt.ol_s1 = s_r.ol;
    rx_nxt.ol_s2 = rx_r.ol_s1;
    rx_nxt.oc_s1 = s_r.oc;
    rx_nxt.oc_s2 = rx_r.oc_s1;
    rx_byte = {rx_r.rx[6:0], i_serial_in};
    if (!started_r)
    begin
      rx_byte = {7'h00, i_serial_in};
      rx_nxt.cnt = 8'h01;
      rx_nxt.found = 1'b0;
      rx_nxt.frame_tgl = ~rx_r.frame_tgl;
      rx_nxt.want_data = 1'b0;
      rx_nxt.tx = {s_r.shadow[6:0], 1'b0};
    end
    else
    begin
      rx_nxt.cnt = (rx_r.cnt == CNT_MAX) ? rx_r.cnt : 8'(rx_r.cnt + 8'h01);
      rx_nxt.tx = {rx_r.tx[6:0], 1'b0};
    end
    rx_nxt.rx = rx_byte;
    if (started_r && (rx_nxt.cnt[2:0] == 3'h0))
    begin
      if (rx_r.want_data)
      begin
        rx_nxt.data = rx_byte;
        rx_nxt.want_data = 1'b0;
        rx_nxt.tx = rx_byte;
      end
      else if (!rx_r.found && rx_byte[TOKEN_BIT])
      begin
        // Own address is the first byte carrying the final address token
        rx_nxt.addr = rx_byte;
        rx_nxt.found = 1'b1;
        rx_nxt.want_data = 1'b1;
        // Live load status so a fault during this byte shows in it
        rx_nxt.tx = read_reg(rx_byte[IDX_MSB:IDX_LSB], s_r.ctrl, s_r.shadow,
                             rx_r.ol_s2, rx_r.oc_s2);
      end
      else
      begin
        rx_nxt.tx = rx_byte;
      end
    end
  end

  always_ff @(negedge i_sclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      rx_r <= '0;
    end
    else
    begin
      rx_r <= rx_nxt;
    end
  end

  // Link domain, rising edge: output bit; first edge takes the status MSB
  always_comb
  begin
    tx_nxt.rose = 1'b1;
    tx_nxt.sdo_bit = tx_r.rose ? rx_r.tx[7] : s_r.shadow[7];
  end

  always_ff @(posedge i_sclk or negedge i_rst_n or posedge i_chip_select_low_n)
  begin
    if (!i_rst_n)
    begin
      tx_r <= '0;
    end
    else if (i_chip_select_low_n)
    begin
      tx_r <= '0;
    end
    else
    begin
      tx_r <= tx_nxt;
    end
  end

  // Before the first rising edge the flag ORs in upstream flags
  assign o_serial_out = tx_r.rose ? tx_r.sdo_bit : (s_r.combined_fault_flag | i_serial_in);
  // Enable follows select directly: a synchronised one would miss the first bits
  assign o_serial_out_oe = i_rst_n & ~i_chip_select_low_n;
  assign o_switch_enables = s_r.switch_out;
  assign o_clock_mod_sel = s_r.clk_mod_out;

endmodule

/* File: hb_spi_pkg.sv */
package hb_spi_pkg;
  // Frame layout
  localparam logic [7:0] MIN_FRAME_BITS = 8'h10;
  localparam logic [7:0] CNT_MAX = 8'hff;
  localparam int OPERATION_BIT = 7;
  localparam int TOKEN_BIT = 1;
  localparam int FRAME_BIT = 0;
  localparam int IDX_MSB = 6;
  localparam int IDX_LSB = 2;
  // Register indices, address bits six down to two
  localparam logic [4:0] ADDR_SWITCH = 5'h00;
  localparam logic [4:0] ADDR_OPEN_LOAD = 5'h01;
  localparam logic [4:0] ADDR_GLOBAL = 5'h06;
  localparam logic [4:0] ADDR_CLK_MOD = 5'h0c;
  localparam logic [4:0] ADDR_OVERCURRENT = 5'h16;
  localparam logic [4:0] ADDR_VARIANT = 5'h19;
  localparam logic [4:0] ADDR_BLANKING = 5'h1a;
  // Global status byte fields
  localparam int GS_SPI_ERR = 7;
  localparam int GS_LOAD = 6;
  localparam int GS_UV = 5;
  localparam int GS_OV = 4;
  localparam int GS_NPOR = 3;
  localparam int GS_TSD = 2;
  localparam int GS_TPW = 1;
  // Control fields and reset values
  localparam logic [7:0] CLK_MOD_MASK = 8'hc0;
  localparam logic [7:0] BLANK_MASK = 8'h80;
  localparam int BLANK_BIT = 7;
  localparam logic [7:0] SWITCH_RST = 8'h00;
  localparam logic [7:0] CLK_MOD_RST = 8'hc0;
  localparam logic [7:0] BLANK_RST = 8'h00;
  localparam logic [7:0] STATUS_RST = 8'h00;
  // Arbitrary variant code
  localparam logic [7:0] VARIANT_ID = 8'h06;

  typedef struct packed {
    logic [7:0] switch_en;
    logic [7:0] clk_mod;
    logic [7:0] blanking;
  } ctrl_regs_t;

  typedef struct packed {
    logic spi_err;
    logic uv;
    logic ov;
    logic npor;
    logic tsd;
    logic tpw;
  } global_bits_t;

  typedef struct packed {
    logic cs_s1;
    logic cs_s2;
    logic cs_d;
    ctrl_regs_t ctrl;
    global_bits_t gb;
    logic [7:0] ol;
    logic [7:0] oc;
    logic new_ol;
    logic new_oc;
    logic new_g;
    logic [7:0] shadow;
    logic combined_fault_flag;
    logic tgl_s1;
    logic tgl_s2;
    logic tgl_seen;
    logic [7:0] switch_out;
    logic [1:0] clk_mod_out;
  } sys_state_t;

  typedef struct packed {
    logic [7:0] cnt;
    logic [7:0] rx;
    logic [7:0] tx;
    logic [7:0] addr;
    logic [7:0] data;
    logic found;
    logic want_data;
    logic frame_tgl;
    logic [7:0] ol_s1;
    logic [7:0] ol_s2;
    logic [7:0] oc_s1;
    logic [7:0] oc_s2;
  } rx_state_t;

  typedef struct packed {
    logic rose;
    logic sdo_bit;
  } tx_state_t;
endpackage

/* File: hb_spi_sva.sv */
`timescale 1ns/1ps
module hb_spi_sva
(
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_sclk,
  input wire logic i_chip_select_low_n,
  input wire logic i_serial_in,
  input wire logic o_serial_out,
  input wire logic o_serial_out_oe,
  input wire logic [7:0] o_switch_enables,
  input wire logic [1:0] o_clock_mod_sel
);
  logic [7:0] rises_r;
  // Rising clocks in this frame; cleared by select so no reset is needed
  always_ff @(posedge i_sclk or posedge i_chip_select_low_n)
  begin
    if (i_chip_select_low_n)
      rises_r <= 8'h00;
    else
      rises_r <= 8'(rises_r + 8'h01);
  end
  sequence deselect_s;
    $rose(i_chip_select_low_n);
  endsequence
  sequence idle_s;
    i_chip_select_low_n [*4];
  endsequence
  oe_release_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    deselect_s |-> !o_serial_out_oe) else $error("output held after deselect");
  oe_drive_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    $fell(i_chip_select_low_n) |-> o_serial_out_oe) else $error("output not driven");
  oe_idle_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    idle_s |-> !o_serial_out_oe) else $error("output driven while idle");
  flag_or_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    !i_chip_select_low_n && rises_r == 8'h00 && i_serial_in |-> o_serial_out) else $error("flag not ORed");
  pass_through_a: assert property (@(negedge i_sclk) disable iff (!i_rst_n)
    rises_r > 8'h18 |-> o_serial_out == $past(i_serial_in, 8)) else $error("byte not passed on");
  switch_exec_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    $changed(o_switch_enables) |-> i_chip_select_low_n && $past(i_chip_select_low_n, 2))
    else $error("switches changed inside frame");
  clkmod_exec_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    !i_chip_select_low_n |-> $stable(o_clock_mod_sel)) else $error("clock select changed inside frame");
  no_cross_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (o_switch_enables & (o_switch_enables >> 1) & 8'h55) == 8'h00) else $error("both switches of a pair on");
endmodule
bind half_bridge_spi_frame_logic hb_spi_sva chk_i (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_sclk(i_sclk),
  .i_chip_select_low_n(i_chip_select_low_n), .i_serial_in(i_serial_in), .o_serial_out(o_serial_out),
  .o_serial_out_oe(o_serial_out_oe), .o_switch_enables(o_switch_enables), .o_clock_mod_sel(o_clock_mod_sel));

/* File: spi_controller_model.sv */
`timescale 1ns/1ps
module spi_controller_model
(
  output logic o_sclk,
  output logic o_cs_n,
  output logic o_sdi,
  input wire logic i_sdo
);
  // Clock stands low and input at its pull-down level between frames
  initial
  begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_sdi = 1'b0;
  end
  // MSB first; one select and clock for the whole chain
  task automatic frame(input int n, input logic [31:0] tx, output logic [31:0] rx);
    rx = '0;
    o_cs_n = 1'b0;
    for (int i = n - 1; i >= 0; i--)
    begin
      #15 o_sclk = 1'b1;
      o_sdi = tx[i];
      #15 o_sclk = 1'b0;
      rx[i] = i_sdo;
    end
    #15 o_sdi = 1'b0;
    o_cs_n = 1'b1;
  endtask
  // Select without clocks, input level chosen by the caller
  task automatic peek(input logic s, output logic o);
    o_cs_n = 1'b0;
    o_sdi = s;
    #200 o = i_sdo;
    o_sdi = 1'b0;
    #15 o_cs_n = 1'b1;
  endtask
endmodule

/* File: tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  import hb_spi_pkg::*;
  logic i_clock = 1'b0;
  logic i_rst_n = 1'b0;
  logic sclk, cs_n, sdi, sdo, oe, b, tsd = 1'b0;
  logic [7:0] ol = 8'h00;
  logic [7:0] oc = 8'h00;
  logic [7:0] sw;
  logic [1:0] cm;
  logic [31:0] rx;
  logic miso;
  // Released line shows the inverse, so a late enable corrupts the first bits
  assign miso = oe ? sdo : ~sdo;
  int failures = 0;
  int checked = 0;
  int cycles = 0;
  spi_controller_model ctl (.o_sclk(sclk), .o_cs_n(cs_n), .o_sdi(sdi), .i_sdo(miso));
  half_bridge_spi_frame_logic DUT (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_sclk(sclk),
    .i_chip_select_low_n(cs_n), .i_serial_in(sdi), .i_open_load(ol), .i_overcurrent(oc),
    .i_vs_uv(1'b0), .i_vs_ov(1'b0), .i_tsd(tsd), .i_tpw(1'b0), .o_serial_out(sdo),
    .o_serial_out_oe(oe), .o_switch_enables(sw), .o_clock_mod_sel(cm));
  always #25 i_clock = ~i_clock;
  task automatic results();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Gap after each frame lets the command land before the next select
  task automatic go(input int n, input logic [31:0] tx);
    ctl.frame(n, tx, rx);
    repeat (6) @(negedge i_clock);
  endtask
  // Hang guard, far above the length of the sequence
  always @(posedge i_clock)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      failures++;
      results();
    end
  end
  initial
  begin
    repeat (10) @(negedge i_clock);
    i_rst_n = 1'b1;
    repeat (4) @(negedge i_clock);
    chk("reset outputs", 32'({sw, cm, oe}), 32'({SWITCH_RST, CLK_MOD_RST[7:6], 1'b0}));
    ctl.peek(1'b0, b);
    chk("flag after reset", 32'(b), 32'h0000_0001);
    repeat (6) @(negedge i_clock);
    go(16, 32'h0000_1b00);
    chk("status after reset", rx, 32'h0000_0000);
    go(16, 32'h0000_8313); // Write with token and frame bit set
    chk("guarded switches", 32'(sw), 32'h0000_0010);
    go(16, 32'h0000_03ff);
    chk("read switches", 32'({sw, rx[7:0]}), 32'h0000_1013);
    go(16, 32'h0000_b340);
    chk("clock select", 32'(cm), 32'h0000_0001);
    go(16, 32'h0000_6700);
    chk("variant", 32'(rx[7:0]), 32'(VARIANT_ID));
    go(12, 32'h0000_01b0);
    go(16, 32'h0000_1b00);
    chk("short frame", 32'(rx[15:8]), 32'h0000_0080);
    go(16, 32'h0000_9b00);
    go(16, 32'h0000_0b00);
    go(16, 32'h0000_1b00);
    chk("unmapped", 32'(rx[15:8]), 32'h0000_0088);
    go(16, 32'h0000_03ff);
    chk("recheck after error", 32'(rx[7:0]), 32'h0000_0013);
    go(16, 32'h0000_9b00);
    go(16, 32'h0000_1b00);
    chk("cleared status", 32'(rx[15:8]), 32'h0000_0008);
    ctl.peek(1'b0, b);
    chk("flag clear", 32'(b), 32'h0000_0000);
    repeat (6) @(negedge i_clock);
    ctl.peek(1'b1, b);
    chk("flag or input", 32'(b), 32'h0000_0001);
    repeat (6) @(negedge i_clock);
    // One-cycle fault events
    oc[2] = 1'b1;
    ol[0] = 1'b1;
    tsd = 1'b1;
    @(negedge i_clock);
    oc = 8'h00;
    ol = 8'h00;
    tsd = 1'b0;
    repeat (4) @(negedge i_clock);
    go(16, 32'h0000_5b00);
    chk("overcurrent read", rx, 32'h0000_4c04);
    // New fault lands in the data byte of a clear
    fork
      go(16, 32'h0000_db00);
      begin
        repeat (7) @(negedge i_clock);
        oc[5] = 1'b1;
        @(negedge i_clock);
        oc[5] = 1'b0;
      end
    join
    go(16, 32'h0000_5b00);
    chk("clear discarded", rx, 32'h0000_4c24);
    // A zero-clock frame after a clear must not clear again
    go(16, 32'h0000_db00);
    oc[1] = 1'b1;
    @(negedge i_clock);
    oc = 8'h00;
    ctl.peek(1'b0, b);
    chk("flag on fault", 32'(b), 32'h0000_0001);
    repeat (6) @(negedge i_clock);
    go(16, 32'h0000_5b00);
    chk("zero clock frame", 32'(rx[7:0]), 32'h0000_0002);
    // Blanking hides the open load from the flag
    go(16, 32'h0000_db00);
    go(16, 32'h0000_9b00);
    go(16, 32'h0000_eb80);
    go(16, 32'h0000_0700);
    chk("open load read", rx, 32'h0000_4801);
    ctl.peek(1'b0, b);
    chk("blanked flag", 32'(b), 32'h0000_0000);
    repeat (6) @(negedge i_clock);
    go(32, 32'h0167_a53c); // Token only in second address byte
    chk("chain slots", 32'(rx[23:0]), 32'({8'h01, VARIANT_ID, 8'ha5}));
    results();
  end
endmodule
